// File: rtl/conv_timer_pkg.sv
// constants for the conversion sequencing timer
package conv_timer_pkg;

	//------------------------------------------------------------
	// timing base
	//------------------------------------------------------------
	localparam int unsigned MOD_CLKS      = 16;
	localparam int unsigned DELAY_DEFAULT = 14;
	localparam int unsigned RATE_CODES    = 14;
	localparam int unsigned CNT_W         = 20;
	localparam int unsigned FIFO_DEPTH    = 8;
	localparam logic [3:0]  RATE_MAX      = 4'hd;
	localparam logic        FILTER_SINC3  = 1'h0;
	localparam logic        FILTER_LOWLAT = 1'h1;

	//------------------------------------------------------------
	// modulator periods per rate code, 2.5 sps up to 4000 sps
	//------------------------------------------------------------
	localparam int unsigned SINC3_FIRST [RATE_CODES] = '{
		307265, 153665, 76865, 46145, 38465, 15425, 12857,
		7745, 3905, 1985, 1025, 808, 424, 232};
	localparam int unsigned LOWLAT_FIRST [RATE_CODES] = '{
		104065, 52865, 27265, 15425, 14465, 5160, 4329,
		2600, 1320, 680, 360, 296, 168, 104};
	localparam int unsigned NEXT_PERIOD [RATE_CODES] = '{
		102400, 51200, 25600, 15360, 12800, 5120, 4264,
		2560, 1280, 640, 320, 256, 128, 64};

	//------------------------------------------------------------
	// sequencer states, gray along idle-delay-conv-hold
	//------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_DELAY = 2'h1,
		ST_CONV  = 2'h3,
		ST_HOLD  = 2'h2
	} seq_state_t;

endpackage

// File: rtl/filter_conversion_timer.sv
// conversion sequencing and result timing for the decimation filter
//
// Operation
// - settling delay first, default 14 modulator periods
// - start on trigger rise or start command
// - later continuous conversions skip settling delay
// - filter select 0 picks sinc3 path
// - sinc3 drops first two results, outputs third
// - sinc3 first result after tabled periods
// - continuous later results after tabled periods
// - sinc3 nulls track data rate
// - sinc3 decimator runs at clock over 16
// - all intervals counted in modulator periods
// - low-latency first and later tabled periods
`timescale 1ns/1ns
`default_nettype none

module filter_conversion_timer #(
	parameter int unsigned DATA_W    = 24,
	parameter int unsigned MOD_CLKS  = conv_timer_pkg::MOD_CLKS,
	parameter int unsigned DELAY_DEF = conv_timer_pkg::DELAY_DEFAULT,
	parameter int unsigned SINC3_FIRST_P  [conv_timer_pkg::RATE_CODES] = conv_timer_pkg::SINC3_FIRST,
	parameter int unsigned LOWLAT_FIRST_P [conv_timer_pkg::RATE_CODES] = conv_timer_pkg::LOWLAT_FIRST,
	parameter int unsigned NEXT_PERIOD_P  [conv_timer_pkg::RATE_CODES] = conv_timer_pkg::NEXT_PERIOD
) (
	input  wire logic              CLK_I,
	input  wire logic              RSTN_I,
	input  wire logic              TRIG_I,
	input  wire logic              START_CMD_I,
	input  wire logic              STOP_CMD_I,
	input  wire logic              CONT_MODE_I,
	input  wire logic              FILTER_SEL_I,
	input  wire logic [3:0]        RATE_I,
	input  wire logic [2:0]        DELAY_SEL_I,
	input  wire logic [DATA_W-1:0] RESULT_I,
	output logic      [DATA_W-1:0] DATA_O,
	output logic                   DATA_VALID_O,
	input  wire logic              DATA_READY_I,
	output logic                   BUSY_O,
	output logic                   MOD_TICK_O
);
	localparam int unsigned CNT_W = conv_timer_pkg::CNT_W;
	localparam int unsigned PH_W  = $clog2(MOD_CLKS);

	if (MOD_CLKS < 2 || (1 << PH_W) != MOD_CLKS || DATA_W < 1 || DELAY_DEF < 1
		|| ((DELAY_DEF << 7) >= (1 << CNT_W))) begin : g_bad_param
		$error("modulator divider or delay out of range");
	end

	// a zero or oversized interval would stall the down counter
	for (genvar i = 0; i < conv_timer_pkg::RATE_CODES; i++) begin : g_len_check
		if (SINC3_FIRST_P[i] < 1 || LOWLAT_FIRST_P[i] < 1 || NEXT_PERIOD_P[i] < 1
			|| SINC3_FIRST_P[i] >= (1 << CNT_W) || LOWLAT_FIRST_P[i] >= (1 << CNT_W)
			|| NEXT_PERIOD_P[i] >= (1 << CNT_W)) begin : g_bad_len
			$error("interval table entry out of counter range");
		end
	end

	conv_timer_pkg::seq_state_t state_reg;
	conv_timer_pkg::seq_state_t state_next;

	logic              trig_meta_reg;
	logic              trig_sync_reg;
	logic              trig_prev_reg;
	logic              start_evt;
	logic [PH_W-1:0]   phase_reg;
	logic              tick;
	logic [CNT_W-1:0]  cnt_reg;
	logic [CNT_W-1:0]  cnt_next;
	logic              cnt_done;
	logic              cont_reg;
	logic              filt_reg;
	logic [3:0]        rate_reg;
	logic [3:0]        rate_eff;
	logic [CNT_W-1:0]  delay_len;
	logic [CNT_W-1:0]  first_len;
	logic [CNT_W-1:0]  next_len;
	logic              push_valid;
	logic              push_ready;
	logic              pushed;

	//------------------------------------------------------------
	// trigger pin synchroniser and start events
	//------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			trig_meta_reg <= 1'b0;
			trig_sync_reg <= 1'b0;
			trig_prev_reg <= 1'b0;
		end else begin
			trig_meta_reg <= TRIG_I;
			trig_sync_reg <= trig_meta_reg;
			trig_prev_reg <= trig_sync_reg;
		end
	end

	// command pulse arrives already aligned to the seventh serial edge
	assign start_evt = (trig_sync_reg && !trig_prev_reg) || START_CMD_I;

	//------------------------------------------------------------
	// modulator period divider, restarted by each start
	//------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I || start_evt) begin
			phase_reg <= '0;
		end else begin
			phase_reg <= phase_reg + 1'b1;
		end
	end

	assign tick       = phase_reg == PH_W'(MOD_CLKS - 1);
	assign MOD_TICK_O = tick;

	//------------------------------------------------------------
	// settings captured at start
	//------------------------------------------------------------
	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			cont_reg <= 1'b0;
			filt_reg <= conv_timer_pkg::FILTER_SINC3;
			rate_reg <= '0;
		end else if (start_evt) begin
			cont_reg <= CONT_MODE_I;
			filt_reg <= FILTER_SEL_I;
			rate_reg <= RATE_I;
		end
	end

	//------------------------------------------------------------
	// interval lookup in modulator periods
	//------------------------------------------------------------
	assign rate_eff  = (rate_reg > conv_timer_pkg::RATE_MAX) ? conv_timer_pkg::RATE_MAX : rate_reg;
	assign delay_len = CNT_W'(DELAY_DEF << DELAY_SEL_I);

	always_comb begin
		if (filt_reg == conv_timer_pkg::FILTER_SINC3) begin
			// covers two suppressed conversions plus the settled one
			first_len = CNT_W'(SINC3_FIRST_P[rate_eff]);
		end else begin
			first_len = CNT_W'(LOWLAT_FIRST_P[rate_eff]);
		end
		next_len = CNT_W'(NEXT_PERIOD_P[rate_eff]);
	end

	//------------------------------------------------------------
	// sequencer
	//------------------------------------------------------------
	assign cnt_done   = tick && (cnt_reg == CNT_W'(1));
	assign push_valid = (state_reg == conv_timer_pkg::ST_CONV && cnt_done)
		|| state_reg == conv_timer_pkg::ST_HOLD;
	assign pushed     = push_valid && push_ready;

	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		if (tick && cnt_reg != '0) begin
			cnt_next = cnt_reg - CNT_W'(1);
		end
		unique case (state_reg)
			conv_timer_pkg::ST_IDLE: begin
			end
			conv_timer_pkg::ST_DELAY: begin
				if (cnt_done) begin
					state_next = conv_timer_pkg::ST_CONV;
					cnt_next   = first_len;
				end
			end
			conv_timer_pkg::ST_CONV, conv_timer_pkg::ST_HOLD: begin
				if (pushed) begin
					if (cont_reg) begin
						state_next = conv_timer_pkg::ST_CONV;
						cnt_next   = next_len;
					end else begin
						state_next = conv_timer_pkg::ST_IDLE;
					end
				end else if (push_valid) begin
					// buffer full: timer waits, result held back
					state_next = conv_timer_pkg::ST_HOLD;
				end
			end
		endcase
		if (STOP_CMD_I) begin
			state_next = conv_timer_pkg::ST_IDLE;
			cnt_next   = '0;
		end
		if (start_evt) begin
			state_next = conv_timer_pkg::ST_DELAY;
			cnt_next   = delay_len;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			state_reg <= conv_timer_pkg::ST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign BUSY_O = state_reg != conv_timer_pkg::ST_IDLE;

	//------------------------------------------------------------
	// settled results into the output buffer
	//------------------------------------------------------------
	result_fifo #(
		.WIDTH (DATA_W),
		.DEPTH (conv_timer_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i       (CLK_I),
		.rstn_i      (RSTN_I),
		.in_data_i   (RESULT_I),
		.in_valid_i  (push_valid),
		.in_ready_o  (push_ready),
		.out_data_o  (DATA_O),
		.out_valid_o (DATA_VALID_O),
		.out_ready_i (DATA_READY_I)
	);

endmodule // filter_conversion_timer

`default_nettype wire

// File: rtl/result_fifo.sv
// result buffer with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none

module result_fifo #(
	parameter int unsigned WIDTH = 24,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rstn_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0]      wr_ptr_reg;
	logic [AW:0]      rd_ptr_reg;
	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
	assign empty       = wr_ptr_reg == rd_ptr_reg;
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign push        = in_valid_i && !full;
	assign pop         = out_ready_i && !empty;
	assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];

	//------------------------------------------------------------
	// storage
	//------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
		end
	end

	//------------------------------------------------------------
	// pointers
	//------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			wr_ptr_reg <= '0;
		end else if (push) begin
			wr_ptr_reg <= wr_ptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rd_ptr_reg <= '0;
		end else if (pop) begin
			rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end

endmodule // result_fifo

`default_nettype wire

// File: testbench/fct_assertions.sv
// port assertions for the conversion timer
`timescale 1ns/1ns
`default_nettype none
module fct_checker #(
	parameter int unsigned DATA_W = 24
) (
	input wire logic              CLK_I,
	input wire logic              RSTN_I,
	input wire logic              START_CMD_I,
	input wire logic              STOP_CMD_I,
	input wire logic              DATA_READY_I,
	input wire logic [DATA_W-1:0] DATA_O,
	input wire logic              DATA_VALID_O,
	input wire logic              BUSY_O,
	input wire logic              MOD_TICK_O
);
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RSTN_I);
	sequence quiet;
		!DATA_VALID_O [*8];
	endsequence
	sequence held;
		DATA_VALID_O && !DATA_READY_I;
	endsequence
	AST_START_BUSY: assert property (START_CMD_I |=> BUSY_O)
		else $error("no busy after start");
	AST_STOP_IDLE: assert property (STOP_CMD_I && !START_CMD_I |=> !BUSY_O)
		else $error("busy after stop");
	AST_TICK_PULSE: assert property (MOD_TICK_O |=> !MOD_TICK_O)
		else $error("tick too long");
	AST_VALID_HOLD: assert property (held |=> DATA_VALID_O)
		else $error("valid dropped");
	AST_DATA_HOLD: assert property (held |=> $stable(DATA_O))
		else $error("data changed");
	AST_PUSH_BUSY: assert property ($rose(DATA_VALID_O) |-> $past(BUSY_O))
		else $error("result while idle");
	AST_SINGLE_DONE: assert property ($fell(BUSY_O) && !$past(STOP_CMD_I) |-> DATA_VALID_O)
		else $error("idle without result");
	AST_SETTLE_QUIET: assert property (START_CMD_I && !DATA_VALID_O |=> quiet)
		else $error("result too early");
endmodule // fct_checker
bind filter_conversion_timer fct_checker #(.DATA_W(DATA_W)) u_chk (.*);
`default_nettype wire

// File: testbench/filter_conversion_timer_tb.sv
// self-checking bench for the conversion timer
`timescale 1ns/1ns
`default_nettype none
module filter_conversion_timer_tb;
	localparam int MC = 2;
	localparam int DD = 2;
	localparam int unsigned S3 [14] = '{9, 8, 7, 6, 5, 4, 3, 9, 8, 7, 6, 5, 4, 3};
	localparam int unsigned LL [14] = '{4, 5, 6, 7, 8, 9, 3, 4, 5, 6, 7, 8, 9, 5};
	localparam int unsigned NX [14] = '{5, 6, 7, 8, 9, 3, 4, 5, 6, 7, 8, 9, 4, 3};
	logic        clk = 0, rstn = 0, cmd = 0, pin = 0, stop = 0, cont = 0, fsel = 0, rdy = 1, tm = 1;
	logic        start, trig, valid, busy, tick;
	logic [3:0]  rate = 0;
	logic [2:0]  dsel = 0;
	logic [23:0] res = 0, dout;
	logic [31:0] rnd = 60707;
	int          cyc = 0, num_errors = 0, checks = 0, c;
	int          due[$], exp_c[$];
	logic [23:0] exp_d[$];

	host_model u_host_model (.clk_i(clk), .cmd_i(cmd), .pin_i(pin), .start_o(start), .trig_o(trig));
	filter_conversion_timer #(
		.MOD_CLKS(MC), .DELAY_DEF(DD), .SINC3_FIRST_P(S3), .LOWLAT_FIRST_P(LL), .NEXT_PERIOD_P(NX)
	) u_filter_conversion_timer (
		.CLK_I(clk), .RSTN_I(rstn), .TRIG_I(trig), .START_CMD_I(start), .STOP_CMD_I(stop),
		.CONT_MODE_I(cont), .FILTER_SEL_I(fsel), .RATE_I(rate), .DELAY_SEL_I(dsel), .RESULT_I(res),
		.DATA_O(dout), .DATA_VALID_O(valid), .DATA_READY_I(rdy), .BUSY_O(busy), .MOD_TICK_O(tick)
	);

	always #5 clk = ~clk;

	function automatic logic [31:0] xs();
		rnd = rnd ^ (rnd << 13);
		rnd = rnd ^ (rnd >> 17);
		rnd = rnd ^ (rnd << 5);
		return rnd;
	endfunction

	task automatic chk(input logic [23:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %0t %h %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// note each result word at its push edge, compare at pop
	always @(posedge clk) begin
		cyc <= cyc + 1;
		res <= 24'(xs());
		if (due.size() > 0 && cyc == due[0]) begin
			void'(due.pop_front());
			chk({22'h0, busy, tick}, 24'h3);
			exp_d.push_back(res);
			exp_c.push_back(tm ? cyc + 1 : 0);
		end
		if (valid === 1'b1 && rdy === 1'b1) begin
			if (exp_d.size() == 0)
				chk({23'h0, valid}, 24'h0);
			else begin
				chk(dout, exp_d.pop_front());
				c = exp_c.pop_front();
				if (c != 0)
					chk(24'(cyc), 24'(c));
			end
		end
	end

	task automatic wait_q(input bit q);
		int i;
		for (i = 0; i < 900 && (q ? due.size() : exp_d.size()) > 0; i++) begin
			@(posedge clk);
			if (!tm && !q)
				rdy <= ^xs();
		end
		if (i == 900) begin
			num_errors++;
			end_sim();
		end
	endtask

	task automatic run(input int r, d, ll, ct, trg, nr);
		int e;
		int m;
		m = (r > 13) ? 13 : r;
		@(posedge clk);
		rate <= 4'(r);
		dsel <= 3'(d);
		fsel <= ll[0];
		cont <= ct[0];
		cmd <= !trg;
		pin <= trg[0];
		e = cyc + (trg ? 4 : 2) + MC * ((DD << d) + (ll ? LL[m] : S3[m]));
		for (int i = 0; i < nr; i++) begin
			due.push_back(e);
			e += MC * NX[m];
		end
		@(posedge clk);
		cmd <= 0;
		pin <= 0;
		wait_q(1);
		stop <= ct[0];
		@(posedge clk);
		stop <= 0;
		wait_q(0);
		@(posedge clk);
		chk({23'h0, busy}, 24'h0);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rstn <= 1;
		for (int r = 0; r < 14; r++)
			run(r, xs() % 8, 0, 0, 0, 1);
		run(13, 2, 1, 0, 1, 1);
		run(2, 0, 1, 1, 0, 3);
		run(15, 1, 0, 1, 1, 3);
		tm <= 0;
		rdy <= 0;
		run(13, 0, 0, 1, 0, 8);
		@(posedge clk);
		chk({23'h0, valid}, 24'h0);
		end_sim();
	end
endmodule // filter_conversion_timer_tb
`default_nettype wire

// File: testbench/host_model.sv
// host side: start command pulse and trigger pin
`timescale 1ns/1ns
`default_nettype none
module host_model (
	input  wire logic clk_i,
	input  wire logic cmd_i,
	input  wire logic pin_i,
	output var logic  start_o,
	output var logic  trig_o
);
	// start pulse marks the seventh falling serial clock edge
	always @(posedge clk_i) begin
		start_o <= cmd_i;
		trig_o <= pin_i;
	end
endmodule // host_model
`default_nettype wire
